/* File: hw/hsf_pkg.sv */
// Purpose: Shared constants for the HDLC status / FIFO-information block
// Assumes: Byte-wide register port, 9-bit register address, one clock
// Notes:   Offsets, bit positions and reset values are named here only once
package hsf_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Device register offsets
  localparam logic [8:0] A_RX_CONTROL      = 9'h010;
  localparam logic [8:0] A_RX_BIT_SUPPRESS = 9'h011;
  localparam logic [8:0] A_RX_FIFO_CONTROL = 9'h087;
  localparam logic [8:0] A_RX_LATCHED      = 9'h094;
  localparam logic [8:0] A_RX_IRQ_MASK     = 9'h0a4;
  localparam logic [8:0] A_RX_REALTIME     = 9'h0b4;
  localparam logic [8:0] A_RX_BYTES_AVAIL  = 9'h0b5;
  localparam logic [8:0] A_RX_FIFO_DATA    = 9'h0b6;
  localparam logic [8:0] A_TX_LATCHED      = 9'h191;
  localparam logic [8:0] A_TX_IRQ_MASK     = 9'h1a1;
  localparam logic [8:0] A_TX_SPACE        = 9'h1b3;
  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned RX_CTRL_RESET_BIT = 6;
  localparam int unsigned RX_LS_PKT_END     = 0;
  localparam int unsigned RX_LS_HWM         = 1;
  localparam int unsigned RX_LS_OVERRUN     = 5;
  localparam int unsigned RX_RT_HWM         = 1;
  localparam int unsigned RX_RT_PS_LSB      = 4;
  localparam int unsigned RX_BA_MSG_BIT     = 7;
  localparam int unsigned TX_LS_LWM         = 0;
  localparam int unsigned TX_LS_UNDERRUN    = 1;
  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] PS_NONE    = 3'h0;
  localparam logic [2:0] PS_OVERRUN = 3'h4;
  ////////////////////////////////////////////////////////////////////////////
  // Host controller: AHB word offsets and command/status fields
  localparam logic [3:0] H_CMD         = 4'h0;
  localparam logic [3:0] H_STAT        = 4'h4;
  localparam int unsigned CMD_ADDR_LSB  = 0;
  localparam int unsigned CMD_WDATA_LSB = 16;
  localparam int unsigned CMD_WRITE_BIT = 24;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_IRQ_BIT  = 1;
  localparam int unsigned STAT_RD_LSB   = 8;
endpackage : hsf_pkg

/* File: hw/hsf_if.sv */
// Purpose: Byte-wide register port between host controller and device
// Assumes: Both ends on hclk; read strobe held two cycles, write one cycle
// Notes:   irq_out_n is active low and driven by the device only
`timescale 1ns/1ns
`default_nettype none
interface hsf_if;
  logic [8:0] addr;      // Register address
  logic [7:0] wdata;     // Write byte
  logic       rd;        // Read strobe, level
  logic       wr;        // Write strobe, one-cycle pulse
  logic [7:0] rdata;     // Read byte, registered in device
  logic       irq_out_n; // Interrupt, active low
  modport dev_mp  (input addr, wdata, rd, wr, output rdata, irq_out_n);
  modport host_mp (output addr, wdata, rd, wr, input rdata, irq_out_n);
endinterface : hsf_if
`default_nettype wire

/* File: hw/hsf_evt_latch.sv */
// Purpose: A group of latched event bits with mask and interrupt pending
// Assumes: Events are one-cycle pulses on hclk
// Notes:   Pending is separate from the latched bit so a read can release irq
`timescale 1ns/1ns
`default_nettype none
module hsf_evt_latch #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Events and host actions
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  input  wire logic         rd_ack,
  input  wire logic [W-1:0] mask,
  // State
  output logic      [W-1:0] latched,
  output logic              irq
);
  logic [W-1:0] pend; // Events not yet seen by a host read

  ////////////////////////////////////////////////////////////////////////////
  // Latched bits: write-one clears, a new event sets, set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched <= '0;
    end else begin
      latched <= (latched & ~clr) | set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending bits: dropped when the host reads the register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= '0;
    end else if (rd_ack) begin
      pend <= set; // Event in the read cycle itself is kept
    end else begin
      pend <= pend | set;
    end
  end

  // Only unmasked pending events reach the interrupt
  assign irq = |(pend & mask);
endmodule : hsf_evt_latch
`default_nettype wire

/* File: hw/hsf_dev.sv */
// Purpose: Device end: HDLC status, masks, interrupt and FIFO information
// Assumes: HDLC engine and host port both run on hclk; no synchronisers
// Notes:   Read data is frozen at the first cycle of a read strobe
//
// Notes on behaviour
// - Latched bit holds until host clears it
// - Writing one clears latched bit, zero keeps
// - Cleared bit sets only on new event
// - Real-time bits follow condition, no history; the packet status field holds the last packet's status
// - Writes never touch real-time bits; a control write with bit six set clears the packet status field
// - Every HDLC latched event has mask bit
// - Unmasked event drives interrupt low
// - Interrupt released after host reads event
// - Transmit space count shows writable bytes
// - Space count stable for whole read
// - Host resets receive controller via bit six
// - Bytes-available: bit seven flag, count low
// - Flag clear: read status for packet field
// - Host enables packet-end and watermark interrupts
// - High-watermark is real-time above watermark
// - Overrun drops packet, empties FIFO, flags it
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module hsf_dev (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Register port to the host
  hsf_if.dev_mp           bus,
  // Receive engine status
  input  wire logic       rx_pkt_end,
  input  wire logic [2:0] rx_pkt_status,
  input  wire logic       rx_overrun,
  input  wire logic       rx_hwm,
  input  wire logic [6:0] rx_level,
  input  wire logic       rx_msg_cont,
  input  wire logic [7:0] rx_data,
  // Receive engine control
  output logic            rx_pop,
  output logic            rx_flush,
  output logic            rx_ctrl_reset,
  output logic      [7:0] rx_control,
  output logic      [7:0] rx_bit_suppress,
  output logic      [7:0] rx_fifo_control,
  // Transmit engine status
  input  wire logic       tx_lwm,
  input  wire logic       tx_underrun,
  input  wire logic [6:0] tx_space
);
  import hsf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       rd_q;        // Read strobe, one cycle late
  logic       rd_start;    // First cycle of a read
  logic       wr_rx_ls;    // Write to receive latched register
  logic       wr_tx_ls;    // Write to transmit latched register
  logic       hwm_q;       // Watermark level, one cycle late
  logic       lwm_q;       // Low-watermark level, one cycle late
  logic [2:0] pkt_stat;    // Packet status field
  logic [7:0] rx_mask;     // Receive interrupt enables, 1 = enabled
  logic [7:0] tx_mask;     // Transmit interrupt enables, 1 = enabled
  logic [7:0] rx_set;      // Receive event pulses
  logic [7:0] tx_set;      // Transmit event pulses
  logic [7:0] rx_ls;       // Receive latched bits
  logic [7:0] tx_ls;       // Transmit latched bits
  logic [7:0] rx_rt;       // Receive real-time register view
  logic [7:0] next_rdata;  // Read value chosen by address
  logic       rx_irq;      // Receive group interrupt
  logic       tx_irq;      // Transmit group interrupt

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode
  // Side effects of a read fire once, on its first cycle only
  assign rd_start = bus.rd & ~rd_q;
  assign wr_rx_ls = bus.wr & (bus.addr == A_RX_LATCHED);
  assign wr_tx_ls = bus.wr & (bus.addr == A_TX_LATCHED);

  // Delayed strobes and levels for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q  <= 1'b0;
      hwm_q <= 1'b0;
      lwm_q <= 1'b0;
    end else begin
      rd_q  <= bus.rd;
      hwm_q <= rx_hwm;
      lwm_q <= tx_lwm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event pulses
  // Level conditions latch only on their rising edge, so a persisting
  // condition does not re-set a bit the host has just cleared
  always_comb begin
    rx_set                = '0;
    rx_set[RX_LS_PKT_END] = rx_pkt_end;
    rx_set[RX_LS_HWM]     = rx_hwm & ~hwm_q;
    rx_set[RX_LS_OVERRUN] = rx_overrun;
    tx_set                = '0;
    tx_set[TX_LS_LWM]     = tx_lwm & ~lwm_q;
    tx_set[TX_LS_UNDERRUN] = tx_underrun;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched status groups
  hsf_evt_latch #(.W(8)) u_rx_latch (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (rx_set),
    .clr     (wr_rx_ls ? bus.wdata : 8'h00),
    .rd_ack  (rd_start & (bus.addr == A_RX_LATCHED)),
    .mask    (rx_mask),
    .latched (rx_ls),
    .irq     (rx_irq)
  );

  hsf_evt_latch #(.W(8)) u_tx_latch (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (tx_set),
    .clr     (wr_tx_ls ? bus.wdata : 8'h00),
    .rd_ack  (rd_start & (bus.addr == A_TX_LATCHED)),
    .mask    (tx_mask),
    .latched (tx_ls),
    .irq     (tx_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output, registered so it is glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus.irq_out_n <= 1'b1;
    end else begin
      bus.irq_out_n <= ~(rx_irq | tx_irq);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_control      <= CFG_RESET;
      rx_bit_suppress <= CFG_RESET;
      rx_fifo_control <= CFG_RESET;
      rx_mask         <= MASK_RESET;
      tx_mask         <= MASK_RESET;
    end else if (bus.wr) begin
      unique case (bus.addr)
        A_RX_CONTROL: begin
          // Reset bit is self-clearing, never stored
          rx_control <= bus.wdata & ~(8'h01 << RX_CTRL_RESET_BIT);
        end
        A_RX_BIT_SUPPRESS: rx_bit_suppress <= bus.wdata;
        A_RX_FIFO_CONTROL: rx_fifo_control <= bus.wdata;
        A_RX_IRQ_MASK:     rx_mask         <= bus.wdata;
        A_TX_IRQ_MASK:     tx_mask         <= bus.wdata;
        default: begin
          // Status and read-only offsets keep their contents
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive controller reset pulse and overrun flush
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ctrl_reset <= 1'b0;
      rx_flush      <= 1'b0;
    end else begin
      rx_ctrl_reset <= bus.wr & (bus.addr == A_RX_CONTROL)
                       & bus.wdata[RX_CTRL_RESET_BIT];
      rx_flush      <= rx_overrun;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet status field
  // Overrun wins over a same-cycle packet end: the packet is dropped anyway
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_stat <= PS_NONE;
    end else if (rx_overrun) begin
      pkt_stat <= PS_OVERRUN;
    end else if (rx_pkt_end) begin
      pkt_stat <= rx_pkt_status;
    end else if (rx_ctrl_reset) begin
      pkt_stat <= PS_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Real-time receive view, built fresh each cycle with no storage of its own
  always_comb begin
    rx_rt                                  = '0;
    rx_rt[RX_RT_HWM]                       = rx_hwm;
    rx_rt[RX_RT_PS_LSB +: 3]               = pkt_stat;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    unique case (bus.addr)
      A_RX_CONTROL:      next_rdata = rx_control;
      A_RX_BIT_SUPPRESS: next_rdata = rx_bit_suppress;
      A_RX_FIFO_CONTROL: next_rdata = rx_fifo_control;
      A_RX_LATCHED:      next_rdata = rx_ls;
      A_RX_IRQ_MASK:     next_rdata = rx_mask;
      A_RX_REALTIME:     next_rdata = rx_rt;
      A_RX_BYTES_AVAIL:  next_rdata = {rx_msg_cont, rx_level};
      A_RX_FIFO_DATA:    next_rdata = rx_data;
      A_TX_LATCHED:      next_rdata = tx_ls;
      A_TX_IRQ_MASK:     next_rdata = tx_mask;
      A_TX_SPACE:        next_rdata = {1'b0, tx_space};
      default:           next_rdata = 8'h00; // Unmapped reads as zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data capture
  // Captured once at the read's first edge and held for the rest of the
  // strobe, so a live count cannot change under the host mid-read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus.rdata <= 8'h00;
    end else if (rd_start) begin
      bus.rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO pop, once per read of the data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pop <= 1'b0;
    end else begin
      rx_pop <= rd_start & (bus.addr == A_RX_FIFO_DATA);
    end
  end
endmodule : hsf_dev
`default_nettype wire

/* File: hw/hsf_host.sv */
// Purpose: Host end: AHB-Lite slave turning commands into port cycles
// Assumes: Single word transfers, zero wait states, same clock as device
// Notes:   A command written while busy is dropped; poll busy first
`timescale 1ns/1ns
`default_nettype none
module hsf_host (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Register port to the device
  hsf_if.host_mp           bus
);
  import hsf_pkg::*;

  typedef enum logic [1:0] {HSF_IDLE, HSF_RD1, HSF_RD2, HSF_WR} hsf_state_t;

  hsf_state_t state;     // Port cycle sequencer
  logic       dp_valid;  // Data phase pending
  logic       dp_wr;     // Pending phase is a write
  logic [3:0] dp_addr;   // Pending word offset
  logic       start;     // Command accepted this cycle
  logic [7:0] rd_byte;   // Last byte read from the device
  logic [31:0] stat;     // Status word view

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign start = dp_valid & dp_wr & (dp_addr == H_CMD) & (state == HSF_IDLE);

  always_comb begin
    stat                     = '0;
    stat[STAT_BUSY_BIT]      = (state != HSF_IDLE);
    stat[STAT_IRQ_BIT]       = ~bus.irq_out_n;
    stat[STAT_RD_LSB +: 8]   = rd_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture; read data registered here (hsize ignored)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_wr    <= 1'b0;
      dp_addr  <= 4'h0;
      hrdata   <= 32'h0000_0000;
    end else begin
      dp_valid <= hsel & hready & htrans[1];
      if (hsel & hready & htrans[1]) begin
        dp_wr   <= hwrite;
        dp_addr <= haddr[3:0];
        hrdata  <= (haddr[3:0] == H_STAT) ? stat : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port cycle sequencer: reads hold the strobe two cycles, writes one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= HSF_IDLE;
      bus.addr  <= 9'h000;
      bus.wdata <= 8'h00;
      rd_byte   <= 8'h00;
    end else begin
      unique case (state)
        HSF_IDLE: if (start) begin
          bus.addr  <= hwdata[CMD_ADDR_LSB +: 9];
          bus.wdata <= hwdata[CMD_WDATA_LSB +: 8];
          state     <= hwdata[CMD_WRITE_BIT] ? HSF_WR : HSF_RD1;
        end
        HSF_RD1: state <= HSF_RD2;
        HSF_RD2: begin
          rd_byte <= bus.rdata;
          state   <= HSF_IDLE;
        end
        HSF_WR:  state <= HSF_IDLE;
      endcase
    end
  end

  assign bus.rd = (state == HSF_RD1) | (state == HSF_RD2);
  assign bus.wr = (state == HSF_WR);
endmodule : hsf_host
`default_nettype wire

/* File: sim/hsf_port_assertions.sv */
// Purpose: Timing checks on the byte-wide register port between the two ends
// Assumes: One clock; the port signals arrive here as plain inputs
// Notes:   Engine-side causes are judged by the bench; this sees the wire only
`timescale 1ns/1ns
`default_nettype none
module hsf_port_checker (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Register port
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [7:0] rdata,
  input wire logic       irq_out_n
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // A read strobe rises, stands two cycles, then falls
  sequence read_strobe;
    $rose(rd) ##1 rd ##1 !rd;
  endsequence
  // Read data captured at the strobe's first cycle
  sequence read_capture;
    $rose(rd) ##1 rd;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_RD_TWO:
    assert property ($rose(rd) |-> read_strobe) else $error("read strobe not two cycles");
  AST_RDATA_ONLY_READ:
    assert property ($changed(rdata) |-> $past(rd) && !$past(rd, 2))
      else $error("read data moved outside a read start");
  AST_RDATA_HOLD:
    assert property (read_capture |=> $stable(rdata) [*2]) else $error("read data not held");
  AST_ADDR_HELD:
    assert property ($rose(rd) |=> $stable(addr) && $stable(wdata))
      else $error("address moved during read");
  AST_WR_PULSE:
    assert property (wr |=> !wr && !rd) else $error("write strobe longer than one cycle");
  AST_NO_OVERLAP:
    assert property (!(rd && wr)) else $error("read and write overlap");
  AST_IRQ_RELEASE:
    assert property ($rose(irq_out_n) |-> $past(rd, 2) || $past(wr, 2))
      else $error("interrupt released without host access");
  AST_RESET_IDLE:
    assert property ($rose(hresetn) |-> irq_out_n && !rd && !wr && rdata == 8'h00)
      else $error("port not idle after reset");
  // Main scenario reached
  cover property ($fell(irq_out_n));
endmodule : hsf_port_checker
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench joining host and device ends over the port
// Assumes: AHB-Lite master in the bench, engine status driven by the bench
// Notes:   Device cycles go through the host command and status words
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hsf_pkg::*;
  // AHB and engine stimulus
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize, rx_pkt_status;
  logic [31:0] haddr, hwdata, hrdata;
  logic        rx_pkt_end, rx_overrun, rx_hwm, rx_msg_cont, tx_lwm, tx_underrun;
  logic [6:0]  rx_level, tx_space;
  logic [7:0]  rx_data, rx_control, rx_bit_suppress, rx_fifo_control, rb;
  logic        rx_pop, rx_flush, rx_ctrl_reset;
  // Counters
  int          n_errors, num_checks, n_pop, n_flush, n_rst, cyc;
  ////////////////////////////////////////////////////////////////////////////
  hsf_if hif ();
  hsf_dev hsf_dev_i (.hclk, .hresetn, .bus(hif), .rx_pkt_end, .rx_pkt_status, .rx_overrun,
    .rx_hwm, .rx_level, .rx_msg_cont, .rx_data, .rx_pop, .rx_flush, .rx_ctrl_reset,
    .rx_control, .rx_bit_suppress, .rx_fifo_control, .tx_lwm, .tx_underrun, .tx_space);
  hsf_host hsf_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .bus(hif));
  hsf_port_checker hsf_port_checker_i (.hclk, .hresetn, .addr(hif.addr), .wdata(hif.wdata),
    .rd(hif.rd), .wr(hif.wr), .rdata(hif.rdata), .irq_out_n(hif.irq_out_n));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, pulse counters and the hang guard
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    n_pop   += (rx_pop === 1'b1);
    n_flush += (rx_flush === 1'b1);
    n_rst   += (rx_ctrl_reset === 1'b1);
    cyc++;
    // Whole run needs a few hundred cycles
    if (cyc == 20000) begin
      n_errors++;
      $display("[ERR] %0t run timed out", $time);
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // One AHB single word transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {28'h0000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb
  // Device access by command word; hit puts a packet end beside the strobe
  task automatic dev(input logic w, input logic [8:0] a, input logic [7:0] d,
                     input logic hit);
    logic [31:0] s;
    ahb(1'b1, H_CMD, {7'h00, w, d, 7'h00, a}, s);
    rx_pkt_end <= hit;
    @(posedge hclk);
    rx_pkt_end <= 1'b0;
    s = 32'h1;
    while (s[STAT_BUSY_BIT] !== 1'b0) ahb(1'b0, H_STAT, 32'h0, s);
    rb = s[STAT_RD_LSB +: 8];
  endtask : dev
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // Engine event pulses: [0] packet end, [1] underrun, [2] overrun
  task automatic pulse(input logic [2:0] m);
    @(posedge hclk);
    {rx_overrun, tx_underrun, rx_pkt_end} <= m;
    @(posedge hclk);
    {rx_overrun, tx_underrun, rx_pkt_end} <= 3'h0;
    repeat (3) @(posedge hclk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  // Latched versus real-time behaviour and clearing
  task automatic t_latch();
    pulse(3'h1);
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h01, "event latched");
    dev(1, A_RX_LATCHED, 8'h00, 0);
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h01, "zero write kept bit");
    dev(1, A_RX_LATCHED, 8'h01, 0);
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h00, "one write cleared bit");
    rx_hwm <= 1'b1;
    dev(0, A_RX_REALTIME, 0, 0);
    check(rb, 8'h02, "watermark level shown");
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h02, "watermark rise latched");
    dev(1, A_RX_REALTIME, 8'hff, 0);
    dev(0, A_RX_REALTIME, 0, 0);
    check(rb, 8'h02, "write left real-time bits");
    dev(1, A_RX_LATCHED, 8'h02, 0);
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h00, "persisting level did not re-set");
    rx_hwm <= 1'b0;
    dev(0, A_RX_REALTIME, 0, 0);
    check(rb, 8'h00, "real-time bit dropped");
    dev(1, A_RX_LATCHED, 8'h01, 1);
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h01, "event beat clear");
    dev(1, A_RX_LATCHED, 8'h01, 0);
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h00, "cleared again");
    $display("test latch done");
  endtask : t_latch
  // Masking, assertion and release of the interrupt
  task automatic t_irq();
    logic [31:0] s;
    pulse(3'h2);
    check({7'h00, hif.irq_out_n}, 8'h01, "masked event kept irq high");
    dev(1, A_TX_LATCHED, 8'h03, 0);
    dev(0, A_TX_LATCHED, 0, 0);
    check(rb, 8'h00, "tx latched cleared");
    dev(1, A_RX_IRQ_MASK, 8'h03, 0);
    dev(1, A_TX_IRQ_MASK, 8'h02, 0);
    dev(0, A_RX_IRQ_MASK, 0, 0);
    check(rb, 8'h03, "mask readback");
    dev(0, A_TX_IRQ_MASK, 0, 0);
    check(rb, 8'h02, "tx mask readback");
    pulse(3'h1);
    check({7'h00, hif.irq_out_n}, 8'h00, "unmasked event drove irq");
    ahb(1'b0, H_STAT, 32'h0, s);
    check({7'h00, s[STAT_IRQ_BIT]}, 8'h01, "status shows irq");
    pulse(3'h2);
    dev(0, A_RX_LATCHED, 0, 0);
    repeat (2) @(posedge hclk);
    check({7'h00, hif.irq_out_n}, 8'h00, "second source holds irq");
    dev(0, A_TX_LATCHED, 0, 0);
    check(rb, 8'h02, "underrun latched");
    repeat (2) @(posedge hclk);
    check({7'h00, hif.irq_out_n}, 8'h01, "irq released by read");
    dev(1, A_RX_LATCHED, 8'h01, 0);
    dev(1, A_TX_LATCHED, 8'h02, 0);
    tx_lwm <= 1'b1;
    repeat (4) @(posedge hclk);
    check({7'h00, hif.irq_out_n}, 8'h01, "masked low watermark");
    dev(0, A_TX_LATCHED, 0, 0);
    check(rb, 8'h01, "low watermark latched");
    tx_lwm <= 1'b0;
    dev(1, A_TX_LATCHED, 8'h01, 0);
    $display("test irq done");
  endtask : t_irq
  // FIFO information, packet status, overrun and controller reset
  task automatic t_fifo();
    int p;
    tx_space <= 7'd64;
    dev(0, A_TX_SPACE, 0, 0);
    check(rb, 8'h40, "tx space full");
    tx_space <= 7'd0;
    dev(0, A_TX_SPACE, 0, 0);
    check(rb, 8'h00, "tx space none");
    {rx_level, rx_msg_cont} <= {7'd3, 1'b1};
    dev(0, A_RX_BYTES_AVAIL, 0, 0);
    check(rb, 8'h83, "continuing count");
    {rx_level, rx_msg_cont, rx_data} <= {7'd64, 1'b0, 8'ha5};
    dev(0, A_RX_BYTES_AVAIL, 0, 0);
    check(rb, 8'h40, "final count");
    p = n_pop;
    dev(0, A_RX_FIFO_DATA, 0, 0);
    check(rb, 8'ha5, "fifo byte");
    check(8'(n_pop - p), 8'h01, "one pop per read");
    rx_pkt_status <= 3'h2;
    pulse(3'h1);
    dev(0, A_RX_REALTIME, 0, 0);
    check(rb, 8'h20, "packet status");
    pulse(3'h4);
    dev(0, A_RX_REALTIME, 0, 0);
    check(rb, {1'b0, PS_OVERRUN, 4'h0}, "overrun status");
    dev(0, A_RX_LATCHED, 0, 0);
    check(rb, 8'h21, "overrun latched");
    check(8'(n_flush), 8'h01, "fifo flushed");
    dev(1, A_RX_BIT_SUPPRESS, 8'h5a, 0);
    dev(1, A_RX_FIFO_CONTROL, 8'h3c, 0);
    check(rx_bit_suppress, 8'h5a, "suppress output");
    check(rx_fifo_control, 8'h3c, "fifo control output");
    dev(0, A_RX_BIT_SUPPRESS, 0, 0);
    check(rb, 8'h5a, "suppress readback");
    dev(1, A_RX_CONTROL, 8'h41, 0);
    check(8'(n_rst), 8'h01, "controller reset pulse");
    check(rx_control, 8'h01, "reset bit not stored");
    dev(0, A_RX_CONTROL, 0, 0);
    check(rb, 8'h01, "control readback");
    dev(0, A_RX_REALTIME, 0, 0);
    check(rb, 8'h00, "status cleared by reset");
    dev(0, 9'h0ff, 0, 0);
    check(rb, 8'h00, "unmapped reads zero");
    check({6'h00, hreadyout, hresp}, 8'h02, "ready and okay response");
    dev(1, A_RX_LATCHED, 8'h21, 0);
    $display("test fifo done");
  endtask : t_fifo
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // Main sequence: ten cycles of reset, then the scenarios
  initial begin
    hresetn = 1'b0;
    hsize = 3'h2;
    {hsel, htrans, haddr, hwrite, hwdata} = 68'h0;
    {rx_pkt_end, rx_overrun, rx_hwm, rx_msg_cont, tx_lwm, tx_underrun} = 6'h00;
    {rx_pkt_status, rx_level, rx_data, tx_space} = 25'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_latch();
    t_irq();
    t_fifo();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
